// >>> pkg/rtc_pkg.sv
// Purpose: Shared constants and types for the low-frequency real-time counter
// Assumes: 32-bit register bus, 12-bit byte address, one word per register
// Notes:   Event vector index: 0 tick, 1 wrap, 2..5 compare channels 0..3
package rtc_pkg;

    localparam int CNT_W    = 24;
    localparam int DIV_W    = 12;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int NUM_CMP  = 4;
    localparam int NUM_EVT  = 2 + NUM_CMP;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_TASK_START  = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_TASK_STOP   = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_TASK_CLEAR  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_TASK_FORCE  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_EVT_TICK    = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_EVT_WRAP    = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_EVT_CMP0    = 12'h140;
    localparam logic [ADDR_W-1:0] OFF_INT_SET     = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_INT_CLR     = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_EN    = 12'h340;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_SET   = 12'h344;
    localparam logic [ADDR_W-1:0] OFF_ROUTE_CLR   = 12'h348;
    localparam logic [ADDR_W-1:0] OFF_COUNT       = 12'h504;
    localparam logic [ADDR_W-1:0] OFF_DIVIDE      = 12'h508;
    localparam logic [ADDR_W-1:0] OFF_CMP0        = 12'h540;
    localparam logic [ADDR_W-1:0] OFF_LF_CTRL     = 12'h600;

    // Bit positions of events in the mask and routing words
    localparam int BIT_TICK     = 0;
    localparam int BIT_WRAP     = 1;
    localparam int BIT_CMP0     = 16;

    // Values after reset and on tasks
    localparam logic [CNT_W-1:0]   COUNT_RESET   = 24'h000000;
    localparam logic [CNT_W-1:0]   COUNT_NEAR    = 24'hfffff0;
    localparam logic [CNT_W-1:0]   COUNT_MAX     = 24'hffffff;
    localparam logic [DIV_W-1:0]   DIVIDE_RESET  = 12'h000;
    localparam logic [CNT_W-1:0]   CMP_RESET     = 24'h000000;
    localparam logic [NUM_EVT-1:0] EVT_RESET     = 6'h00;

    // Bus wait after a count read
    localparam logic [1:0] READ_STALL_CYCLES = 2'h3;

    // Task slots in the pending vector
    localparam int TSK_START = 0;
    localparam int TSK_STOP  = 1;
    localparam int TSK_CLEAR = 2;
    localparam int TSK_FORCE = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

endpackage : rtc_pkg

// >>> hdl/low_freq_realtime_counter.sv
// Purpose: 24-bit real-time counter stepped by a divided low-frequency clock
// Assumes: low_freq_clock_in is a slow pin sampled by clk_sys_in (100 MHz)
// Notes:   Tasks act on a falling then rising low-frequency edge
//
// Contract
// - Keep a 24-bit count and a 12-bit divide setting.
// - Count rate is low-frequency clock divided by setting plus one.
// - Divide setting writable only while stopped; writes ignored while running.
// - Start, clear and force tasks reload the internal divider from the setting.
// - Count steps when internal divider is zero, then divider reloads.
// - Tick event on every step when routed; off after reset.
// - Force task loads the count with 0xfffff0.
// - Wrap event when count goes 0xffffff to zero, if routed; off after reset.
// - Each event has a routing enable; unrouted events request no fast clock.
// - Clear task never raises a compare event, even for compare value zero.
// - Start task never raises a compare event on an already equal value.
// - Compare event when count steps from value minus one onto the value.
// - Writing N+2 with count at N always gives an event at N+2.
// - Old compare values above N+2 give no event after a rewrite.
// - Bus count read samples the live count at read time.
// - Clear, stop and force wait for a falling then rising slow edge.
// - First step after start follows on later slow edges.
// - Force task requests the slow clock and waits for its edges.
// - Count read holds bus ready low three cycles.
// - Four compare channels, each with its own event flag.
`timescale 1ns/100ps
module low_freq_realtime_counter
    import rtc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_sys_in,
    input  wire logic              arst_n_in,
    input  wire logic              clk_en_in,
    // Register bus
    input  wire bus_req_t          bus_req_in,
    output logic [DATA_W-1:0]      bus_rdata_out,
    output logic                   bus_ready_out,
    // Low-frequency clock pin and clock requests
    input  wire logic              low_freq_clock_in,
    output logic                   low_freq_clock_req_out,
    output logic                   high_freq_clock_req_out,
    // Interrupt
    output logic                   irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [CNT_W-1:0]    counter_reg;
    logic [DIV_W-1:0]    divide_reg;
    logic [DIV_W-1:0]    internal_divider_count;
    logic [CNT_W-1:0]    compare_value [NUM_CMP];
    logic                running_reg;
    logic [3:0]          pend_reg;
    logic                fall_seen_reg;
    logic [NUM_EVT-1:0]  flag_reg;
    logic [NUM_EVT-1:0]  int_mask_reg;
    logic [NUM_EVT-1:0]  event_routing_enable;
    logic                lf_on_reg;
    logic                hf_req_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [1:0]          stall_reg;
    logic                lf_s1_reg;
    logic                lf_s2_reg;
    logic                lf_s3_reg;
    logic                lf_rise;
    logic                lf_fall;
    logic                apply;
    logic                step;
    logic [CNT_W-1:0]    count_plus;
    logic [NUM_EVT-1:0]  evt_raw;
    logic                wr;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [NUM_CMP-1:0]  cmp_hit_sel;
    logic [NUM_EVT-1:0]  evt_hit_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Spread the event vector into its word bit positions
    function automatic logic [DATA_W-1:0] evt_to_word(input logic [NUM_EVT-1:0] e);
        logic [DATA_W-1:0] w;
        w = '0;
        w[BIT_TICK] = e[0];
        w[BIT_WRAP] = e[1];
        for (int i = 0; i < NUM_CMP; i++) begin
            w[BIT_CMP0 + i] = e[2 + i];
        end
        return w;
    endfunction : evt_to_word

    function automatic logic [NUM_EVT-1:0] word_to_evt(input logic [DATA_W-1:0] w);
        logic [NUM_EVT-1:0] e;
        e = '0;
        e[0] = w[BIT_TICK];
        e[1] = w[BIT_WRAP];
        for (int i = 0; i < NUM_CMP; i++) begin
            e[2 + i] = w[BIT_CMP0 + i];
        end
        return e;
    endfunction : word_to_evt

    // One-hot select of the event flag register at an address
    function automatic logic [NUM_EVT-1:0] evt_sel(input logic [ADDR_W-1:0] a);
        logic [NUM_EVT-1:0] s;
        s = '0;
        s[0] = (a == OFF_EVT_TICK);
        s[1] = (a == OFF_EVT_WRAP);
        for (int i = 0; i < NUM_CMP; i++) begin
            s[2 + i] = (a == OFF_EVT_CMP0 + ADDR_W'(4 * i));
        end
        return s;
    endfunction : evt_sel

    function automatic logic [NUM_CMP-1:0] cmp_sel(input logic [ADDR_W-1:0] a);
        logic [NUM_CMP-1:0] s;
        s = '0;
        for (int i = 0; i < NUM_CMP; i++) begin
            s[i] = (a == OFF_CMP0 + ADDR_W'(4 * i));
        end
        return s;
    endfunction : cmp_sel

    assign wr    = bus_req_in.wr;
    assign rd    = bus_req_in.rd;
    assign addr  = bus_req_in.addr;
    assign wdata = bus_req_in.wdata;

    // Decoded once here, since a function result cannot be indexed in place
    assign cmp_hit_sel = cmp_sel(addr);
    assign evt_hit_sel = evt_sel(addr);

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock sampling; only the second and third stages feed the edge detector

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lf_s1_reg <= 1'b0;
            lf_s2_reg <= 1'b0;
            lf_s3_reg <= 1'b0;
        end else if (clk_en_in) begin
            lf_s1_reg <= low_freq_clock_in;
            lf_s2_reg <= lf_s1_reg;
            lf_s3_reg <= lf_s2_reg;
        end
    end

    assign lf_rise = lf_s2_reg & ~lf_s3_reg;
    assign lf_fall = ~lf_s2_reg & lf_s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Task capture and release on a fall followed by a rise

    assign apply = lf_rise & fall_seen_reg & (pend_reg != 4'h0);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_reg      <= 4'h0;
            fall_seen_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (apply) begin
                fall_seen_reg <= 1'b0;
            end else if (lf_fall && pend_reg != 4'h0) begin
                fall_seen_reg <= 1'b1;
            end
            // A task written on the release edge waits for the next pair
            pend_reg[TSK_START] <= (pend_reg[TSK_START] & ~apply)
                | (wr & addr == OFF_TASK_START & wdata[0]);
            pend_reg[TSK_STOP]  <= (pend_reg[TSK_STOP] & ~apply)
                | (wr & addr == OFF_TASK_STOP & wdata[0]);
            pend_reg[TSK_CLEAR] <= (pend_reg[TSK_CLEAR] & ~apply)
                | (wr & addr == OFF_TASK_CLEAR & wdata[0]);
            pend_reg[TSK_FORCE] <= (pend_reg[TSK_FORCE] & ~apply)
                | (wr & addr == OFF_TASK_FORCE & wdata[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock request: software bit, or a pending force task

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lf_on_reg <= 1'b0;
        end else if (clk_en_in && wr && addr == OFF_LF_CTRL) begin
            lf_on_reg <= wdata[0];
        end
    end

    assign low_freq_clock_req_out = lf_on_reg | pend_reg[TSK_FORCE];

    ////////////////////////////////////////////////////////////////////////////
    // Run state and divide setting

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            running_reg <= 1'b0;
        end else if (clk_en_in && apply) begin
            if (pend_reg[TSK_STOP]) begin
                running_reg <= 1'b0;
            end else if (pend_reg[TSK_START]) begin
                running_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            divide_reg <= DIVIDE_RESET;
        end else if (clk_en_in && wr && addr == OFF_DIVIDE && !running_reg) begin
            divide_reg <= wdata[DIV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider and counter; a task edge never also steps the count

    assign step       = lf_rise & running_reg & ~apply
                        & (internal_divider_count == DIVIDE_RESET);
    assign count_plus = counter_reg + 24'h000001;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            internal_divider_count <= DIVIDE_RESET;
        end else if (clk_en_in) begin
            if (apply && (pend_reg[TSK_START] | pend_reg[TSK_CLEAR]
                          | pend_reg[TSK_FORCE])) begin
                internal_divider_count <= divide_reg;
            end else if (step) begin
                internal_divider_count <= divide_reg;
            end else if (lf_rise && running_reg) begin
                internal_divider_count <= internal_divider_count - 12'h001;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            counter_reg <= COUNT_RESET;
        end else if (clk_en_in) begin
            if (apply && pend_reg[TSK_CLEAR]) begin
                counter_reg <= COUNT_RESET;
            end else if (apply && pend_reg[TSK_FORCE]) begin
                counter_reg <= COUNT_NEAR;
            end else if (step) begin
                counter_reg <= count_plus;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare channels; new values apply at once, so an old value cannot fire

    generate
        for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
            always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    compare_value[i] <= CMP_RESET;
                end else if (clk_en_in && wr && cmp_hit_sel[i]) begin
                    compare_value[i] <= wdata[CNT_W-1:0];
                end
            end
            // Only a real step matches: clear and start edges never do
            assign evt_raw[2 + i] = step & (count_plus == compare_value[i]);
        end
    endgenerate

    assign evt_raw[0] = step;
    assign evt_raw[1] = step & (counter_reg == COUNT_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Routing, mask and sticky flags; a new event wins over a clear

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            event_routing_enable <= EVT_RESET;
        end else if (clk_en_in && wr) begin
            if (addr == OFF_ROUTE_EN) begin
                event_routing_enable <= word_to_evt(wdata);
            end else if (addr == OFF_ROUTE_SET) begin
                event_routing_enable <= event_routing_enable | word_to_evt(wdata);
            end else if (addr == OFF_ROUTE_CLR) begin
                event_routing_enable <= event_routing_enable & ~word_to_evt(wdata);
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            int_mask_reg <= EVT_RESET;
        end else if (clk_en_in && wr) begin
            if (addr == OFF_INT_SET) begin
                int_mask_reg <= int_mask_reg | word_to_evt(wdata);
            end else if (addr == OFF_INT_CLR) begin
                int_mask_reg <= int_mask_reg & ~word_to_evt(wdata);
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag_reg <= EVT_RESET;
        end else if (clk_en_in) begin
            for (int i = 0; i < NUM_EVT; i++) begin
                if (evt_raw[i] && event_routing_enable[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (wr && evt_hit_sel[i]) begin
                    flag_reg[i] <= wdata[0];
                end
            end
        end
    end

    // Fast clock is wanted for one cycle after each step that raises any routed event
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hf_req_reg <= 1'b0;
        end else if (clk_en_in) begin
            hf_req_reg <= |(evt_raw & event_routing_enable);
        end
    end

    assign high_freq_clock_req_out = hf_req_reg;
    assign irq_out                 = |(flag_reg & int_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read path and count-read stall

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= '0;
        end else if (clk_en_in && rd) begin
            rdata_reg <= '0;
            if (addr == OFF_COUNT) begin
                rdata_reg <= DATA_W'(counter_reg);
            end else if (addr == OFF_DIVIDE) begin
                rdata_reg <= DATA_W'(divide_reg);
            end else if (addr == OFF_ROUTE_EN || addr == OFF_ROUTE_SET
                         || addr == OFF_ROUTE_CLR) begin
                rdata_reg <= evt_to_word(event_routing_enable);
            end else if (addr == OFF_INT_SET || addr == OFF_INT_CLR) begin
                rdata_reg <= evt_to_word(int_mask_reg);
            end else if (addr == OFF_LF_CTRL) begin
                rdata_reg <= {30'h00000000, running_reg, lf_on_reg};
            end else if (|evt_sel(addr)) begin
                rdata_reg <= DATA_W'(|(evt_sel(addr) & flag_reg));
            end else begin
                for (int i = 0; i < NUM_CMP; i++) begin
                    if (cmp_hit_sel[i]) begin
                        rdata_reg <= DATA_W'(compare_value[i]);
                    end
                end
            end
        end
    end

    // Ready is advisory here: data still arrive in the next cycle
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stall_reg <= 2'h0;
        end else if (clk_en_in) begin
            if (rd && addr == OFF_COUNT) begin
                stall_reg <= READ_STALL_CYCLES;
            end else if (stall_reg != 2'h0) begin
                stall_reg <= stall_reg - 2'h1;
            end
        end
    end

    assign bus_rdata_out = rdata_reg;
    assign bus_ready_out = (stall_reg == 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);

    property p_divide_locked;
        clk_en_in && running_reg && wr && addr == OFF_DIVIDE |=> $stable(divide_reg);
    endproperty
    a_divide_locked: assert property (p_divide_locked)
        else $error("divide setting changed while running");

    property p_step_count;
        clk_en_in && step |=> counter_reg == $past(counter_reg) + 24'h000001;
    endproperty
    a_step_count: assert property (p_step_count)
        else $error("count did not advance on step");

    property p_task_reload;
        clk_en_in && apply && pend_reg[TSK_CLEAR]
            |=> internal_divider_count == $past(divide_reg) && counter_reg == COUNT_RESET;
    endproperty
    a_task_reload: assert property (p_task_reload)
        else $error("clear task did not reload divider and count");

    property p_force_load;
        clk_en_in && apply && pend_reg[TSK_FORCE] && !pend_reg[TSK_CLEAR]
            |=> counter_reg == COUNT_NEAR;
    endproperty
    a_force_load: assert property (p_force_load)
        else $error("force task did not load near-wrap value");

    property p_tick_routed;
        $rose(flag_reg[0]) |-> $past(event_routing_enable[0]) && $past(step);
    endproperty
    a_tick_routed: assert property (p_tick_routed)
        else $error("tick flag set without routed step");

    property p_wrap_flag;
        clk_en_in && step && counter_reg == COUNT_MAX && event_routing_enable[1]
            |=> flag_reg[1] && counter_reg == COUNT_RESET;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("wrap not flagged");

    property p_fast_req;
        high_freq_clock_req_out |-> $past(|(evt_raw & event_routing_enable));
    endproperty
    a_fast_req: assert property (p_fast_req)
        else $error("fast clock requested for unrouted event");

    property p_clear_quiet;
        clk_en_in && apply && (pend_reg[TSK_CLEAR] | pend_reg[TSK_START])
            |=> flag_reg[NUM_EVT-1:2] == $past(flag_reg[NUM_EVT-1:2]);
    endproperty
    a_clear_quiet: assert property (p_clear_quiet)
        else $error("compare flagged on clear or start");

    property p_cmp_hit;
        clk_en_in && step && count_plus == compare_value[0] && event_routing_enable[2]
            |=> flag_reg[2];
    endproperty
    a_cmp_hit: assert property (p_cmp_hit)
        else $error("compare 0 missed");

    property p_task_wait;
        clk_en_in && pend_reg != 4'h0 && !fall_seen_reg |-> !apply;
    endproperty
    a_task_wait: assert property (p_task_wait)
        else $error("task applied before falling edge");

    property p_read_low;
        clk_en_in && rd && addr == OFF_COUNT |=> !bus_ready_out[*3];
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("ready not held low after count read");

    property p_read_stall;
        clk_en_in && rd && addr == OFF_COUNT ##1 (clk_en_in && !rd)[*3]
            |=> bus_ready_out;
    endproperty
    a_read_stall: assert property (p_read_stall)
        else $error("count read stall not three cycles");

    c_step:  cover property (clk_en_in && step);
    c_wrap:  cover property (clk_en_in && step && counter_reg == COUNT_MAX);
    c_cmp:   cover property (flag_reg[2] && !$past(flag_reg[2]));
    c_force: cover property (clk_en_in && apply && pend_reg[TSK_FORCE]);

endmodule : low_freq_realtime_counter

// >>> testbench/lf_clock_source.sv
// Purpose: Slow clock source that runs only while the counter asks for it
// Assumes: Half period is shortened so that a run stays short
// Notes:   Held low while not requested, like an oscillator that is off
`timescale 1ns/100ps
module lf_clock_source #(
    parameter int HALF_NS = 100
) (
    // Request
    input  wire logic req_in,
    // Clock
    output logic      clk_out
);
    initial clk_out = 1'b0;
    always begin
        #(HALF_NS);
        clk_out = req_in ? ~clk_out : 1'b0;
    end
endmodule : lf_clock_source

// >>> testbench/low_freq_realtime_counter_tb.sv
// Purpose: Self-checking bench for the real-time counter
// Assumes: Slow clock period 200 ns, divide setting 1 (two rises per step)
// Notes:   Flags are polled over the bus, so times carry a few cycles of slack
`timescale 1ns/100ps
module low_freq_realtime_counter_tb;
    import rtc_pkg::*;
    logic              clk_sys_in = 1'b0;
    logic              arst_n_in  = 1'b0;
    bus_req_t          bus_req_in = '0;
    logic [DATA_W-1:0] bus_rdata_out;
    logic [DATA_W-1:0] d;
    logic              bus_ready_out, lf_clk, lf_req, hf_req, irq_out;
    logic              clk_en = 1'b1;
    int                hf_seen = 0;
    int                err_total = 0;
    int                samples_checked = 0;
    longint            t0;
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (hf_req) hf_seen++;
    low_freq_realtime_counter i_low_freq_realtime_counter (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en),
        .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
        .bus_ready_out(bus_ready_out), .low_freq_clock_in(lf_clk),
        .low_freq_clock_req_out(lf_req), .high_freq_clock_req_out(hf_req),
        .irq_out(irq_out));
    lf_clock_source i_lf_clock_source (.req_in(lf_req), .clk_out(lf_clk));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        bus_req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus_req_in.wr <= 1'b0;
    endtask : wr
    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys_in);
        bus_req_in <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus_req_in.rd <= 1'b0;
        #1 d = bus_rdata_out;
    endtask : rd
    task automatic wait_flag(input logic [ADDR_W-1:0] a, input string n);
        int k;
        k = 0;
        rd(a);
        while (d[0] !== 1'b1 && k < 1000) begin
            rd(a);
            k++;
        end
        chk(n, 32'h1, d);
    endtask : wait_flag
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFF_DIVIDE); chk("divide", 32'h0, d);
        rd(OFF_ROUTE_EN); chk("routing", 32'h0, d);
        chk("irq", 32'h0, irq_out);
        chk("clock request", 32'h0, lf_req);
        chk("fast request", 32'h0, hf_req);
    endtask : t_reset
    task automatic t_count;
        wr(OFF_LF_CTRL, 32'h1);
        wr(OFF_DIVIDE, 32'h1);
        rd(OFF_DIVIDE); chk("divide", 32'h1, d);
        chk("clock request", 32'h1, lf_req);
        wr(OFF_CMP0, 32'h2);
        wr(OFF_CMP0 + 12'h004, 32'h0);
        wr(OFF_ROUTE_SET, 32'h30003);
        wr(OFF_INT_SET, 32'h1);
        wr(OFF_TASK_START, 32'h1);
        wait_flag(OFF_EVT_TICK, "tick");
        chk("irq", 32'h1, irq_out);
        rd(OFF_COUNT); chk("count", 32'h1, d);
        wait_flag(OFF_EVT_CMP0, "compare0");
        rd(OFF_COUNT); chk("count", 32'h2, d);
        rd(OFF_EVT_CMP0 + 12'h004); chk("compare1", 32'h0, d);
        wr(OFF_DIVIDE, 32'h5);
        rd(OFF_DIVIDE); chk("divide", 32'h1, d);
        wr(OFF_EVT_TICK, 32'h0);
        wait_flag(OFF_EVT_TICK, "tick");
        t0 = $time;
        wr(OFF_EVT_TICK, 32'h0);
        wait_flag(OFF_EVT_TICK, "tick");
        chk("spacing", 32'h1, ($time - t0 > 360) && ($time - t0 < 440));
        // Frozen for 100 cycles: without the freeze two or three steps would pass
        rd(OFF_COUNT);
        t0 = d;
        @(posedge clk_sys_in);
        clk_en <= 1'b0;
        repeat (100) @(posedge clk_sys_in);
        clk_en <= 1'b1;
        rd(OFF_COUNT); chk("frozen", 32'h1, d - t0[31:0] < 2);
        rd(OFF_COUNT);
        wr(OFF_ROUTE_SET, 32'h40000);
        wr(OFF_CMP0 + 12'h008, d + 32'h2);
        wait_flag(OFF_EVT_CMP0 + 12'h008, "compare2");
        chk("fast seen", 32'h1, hf_seen > 0);
    endtask : t_count
    task automatic t_read;
        @(posedge clk_sys_in);
        bus_req_in <= '{addr: OFF_COUNT, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus_req_in.rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            #1 chk("ready", (i == 3), bus_ready_out);
            @(posedge clk_sys_in);
        end
    endtask : t_read
    task automatic t_wrap;
        wr(OFF_TASK_FORCE, 32'h1);
        rd(OFF_COUNT); chk("early", 32'h0, d[23:0] === COUNT_NEAR);
        repeat (35) @(posedge clk_sys_in);
        rd(OFF_COUNT); chk("count", COUNT_NEAR, d);
        wait_flag(OFF_EVT_WRAP, "wrap");
        rd(OFF_COUNT); chk("count", 32'h0, d);
    endtask : t_wrap
    task automatic t_clear_stop;
        wr(OFF_EVT_CMP0 + 12'h004, 32'h0);
        wr(OFF_TASK_CLEAR, 32'h1);
        repeat (50) @(posedge clk_sys_in);
        rd(OFF_COUNT); chk("cleared", 32'h1, d < 2);
        rd(OFF_EVT_CMP0 + 12'h004); chk("compare1", 32'h0, d);
        wr(OFF_ROUTE_EN, 32'h0);
        repeat (2) @(posedge clk_sys_in);
        t0 = hf_seen;
        repeat (100) @(posedge clk_sys_in);
        chk("fast request", t0[31:0], hf_seen);
        wr(OFF_TASK_STOP, 32'h1);
        repeat (50) @(posedge clk_sys_in);
        rd(OFF_COUNT);
        t0 = d;
        repeat (100) @(posedge clk_sys_in);
        rd(OFF_COUNT); chk("stopped", t0[31:0], d);
    endtask : t_clear_stop
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        t_reset();
        t_count();
        t_read();
        t_wrap();
        t_clear_stop();
        wrap_up();
    end
    // Whole sequence needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        err_total++;
        wrap_up();
    end
endmodule : low_freq_realtime_counter_tb
